// ===== include/fpc_pkg.sv
// Constants for the flash protection command controller.
// Assumes a 16-bit parallel NOR flash bus driven by the controller.
package fpc_pkg;
    // ----------------------------------------
    // Timing at the 25 MHz ref_clk
    // ----------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int UNLOCK_GAP_NS = 1000;
    localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_NS = 80;
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
    // ----------------------------------------
    // Flash command addresses and data (16-bit mode)
    // ----------------------------------------
    localparam logic [11:0] FA_UNL1 = 12'h555;
    localparam logic [11:0] FA_UNL2 = 12'h2AA;
    localparam logic [7:0] FD_UNL1 = 8'hAA;
    localparam logic [7:0] FD_UNL2 = 8'h55;
    localparam logic [7:0] FD_ENT_XBLK = 8'h88;
    localparam logic [7:0] FD_ENT_LOCKREG = 8'h40;
    localparam logic [7:0] FD_ENT_PWD = 8'h60;
    localparam logic [7:0] FD_ENT_NVG = 8'hC0;
    localparam logic [7:0] FD_ENT_FRZ = 8'h50;
    localparam logic [7:0] FD_ENT_VG = 8'hE0;
    localparam logic [7:0] FD_EXIT1 = 8'h90;
    localparam logic [7:0] FD_EXIT2 = 8'h00;
    localparam logic [7:0] FD_PROG = 8'hA0;
    localparam logic [7:0] FD_ERASE = 8'h80;
    localparam logic [7:0] FD_CLR_ALL = 8'h30;
    localparam logic [7:0] FD_PWU_1 = 8'h25;
    localparam logic [7:0] FD_PWU_2 = 8'h03;
    localparam logic [7:0] FD_PWU_END = 8'h29;
    localparam logic [7:0] FD_GUARD_SET = 8'h00;
    localparam logic [7:0] FD_GUARD_CLR = 8'h01;
    localparam logic [7:0] FD_ALL_ONES = 8'hFF;
    // ----------------------------------------
    // Software registers of the controller
    // ----------------------------------------
    localparam logic [3:0] RA_CMD = 4'h0;
    localparam logic [3:0] RA_ADDR = 4'h1;
    localparam logic [3:0] RA_DATA = 4'h2;
    localparam logic [3:0] RA_STATUS = 4'h3;
    localparam logic [3:0] RA_RDATA = 4'h4;
    localparam logic [3:0] RA_PWD0 = 4'h8;
    // Operation codes written to RA_CMD
    typedef enum logic [3:0] {
        FPC_OP_ENT_XBLK = 4'h1,
        FPC_OP_EXIT_XBLK = 4'h2,
        FPC_OP_ENT_LOCKREG = 4'h3,
        FPC_OP_ENT_PWD = 4'h4,
        FPC_OP_ENT_NVG = 4'h5,
        FPC_OP_ENT_FRZ = 4'h6,
        FPC_OP_ENT_VG = 4'h7,
        FPC_OP_EXIT_SET = 4'h8,
        FPC_OP_PROGRAM = 4'h9,
        FPC_OP_CLR_ALL = 4'hA,
        FPC_OP_PWD_UNLOCK = 4'hB,
        FPC_OP_VG_CLEAR = 4'hC,
        FPC_OP_READ = 4'hD,
        FPC_OP_ERASE = 4'hE
    } fpc_op_t;
    // Mode the controller believes the flash is in
    typedef enum logic [2:0] {
        FPC_M_READ = 3'b000,
        FPC_M_XBLK = 3'b001,
        FPC_M_LOCKREG = 3'b010,
        FPC_M_PWD = 3'b011,
        FPC_M_NVG = 3'b100,
        FPC_M_FRZ = 3'b101,
        FPC_M_VG = 3'b110
    } fpc_mode_t;
    localparam int SEQ_MAX = 7;
endpackage

// ===== hw/fpc_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, timed in ref_clk cycles.
// Assumes the flash pins are sampled by no other module; data in is synchronised here.
`timescale 1ns/1ps
module fpc_bus_cycle
    import fpc_pkg::*;
#(
    parameter int ADDR_W = 23,
    parameter int PULSE = PULSE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    output logic [ADDR_W-1:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in
);
    initial begin
        // Two strobe cycles let read data clear both sync flops before done
        if (PULSE < 2 || PULSE > 253) $error("PULSE out of range");
    end

    logic [7:0] cnt_reg;
    logic busy_reg;
    logic wr_reg;
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;

    // ----------------------------------------
    // Strobe timing
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            fl_addr <= '0;
            fl_dq_out <= 16'h0000;
        end else if (start && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= 8'(PULSE + 2);
            wr_reg <= is_write;
            fl_addr <= addr;
            fl_dq_out <= wdata;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) busy_reg <= 1'b0;
        end
    end

    // Pin data passes two flops before use
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            rdata <= 16'h0000;
        end else begin
            sync1_reg <= fl_dq_in;
            sync2_reg <= sync1_reg;
            // Track pin data through a read; settled word is in place at done
            if (busy_reg && !wr_reg) rdata <= sync2_reg;
        end
    end

    assign done = busy_reg && cnt_reg == 8'h01;
    assign fl_ce_n = !busy_reg;
    assign fl_we_n = !(busy_reg && wr_reg && cnt_reg > 8'h01 && cnt_reg <= 8'(PULSE + 1));
    assign fl_oe_n = !(busy_reg && !wr_reg);
    assign fl_dq_oe = busy_reg && wr_reg;
endmodule

// ===== hw/fpc_ctrl.sv
// Host controller issuing flash protection command sequences.
// Assumes software drives the register port; flash pins via fpc_bus_cycle.
//
// What this block does
// - Three writes enter extended block mode
// - Four writes exit extended block mode
// - Lock register entry, exit via 90/00
// - Password programmed as four word programs
// - At least 1 us between unlock commands
// - Exit sequence 90 then 00 anywhere
`timescale 1ns/1ps
module fpc_ctrl
    import fpc_pkg::*;
#(
    parameter int ADDR_W = 23,
    parameter int GAP_CYC = UNLOCK_GAP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [ADDR_W-1:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in
);
    initial begin
        if (ADDR_W < 12) $error("ADDR_W too small");
        if (GAP_CYC < 1 || GAP_CYC > 65535) $error("GAP_CYC out of range");
    end

    typedef enum logic [1:0] {
        FPC_S_IDLE = 2'b00,
        FPC_S_RUN = 2'b01,
        FPC_S_WAIT = 2'b10
    } fpc_state_t;

    fpc_state_t state_reg;
    fpc_mode_t mode_reg;
    logic [3:0] op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [15:0] data_reg;
    logic [15:0] pwd_reg [4];
    logic [2:0] step_reg;
    logic [2:0] len_reg;
    logic [15:0] gap_reg;
    logic refused_reg;
    logic [15:0] rd_reg;
    logic [ADDR_W-1:0] cyc_addr;
    logic [15:0] cyc_data;
    logic cyc_wr;
    logic cyc_start;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic last_step;
    logic op_ok;
    logic cmd_go;
    fpc_mode_t mode_next;

    // ----------------------------------------
    // One flash bus cycle engine
    // ----------------------------------------
    fpc_bus_cycle #(.ADDR_W(ADDR_W)) u_cyc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(cyc_start),
        .is_write(cyc_wr),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .fl_addr(fl_addr),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n),
        .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_in(fl_dq_in)
    );

    // Operation legality against tracked mode
    always_comb begin
        op_ok = 1'b1;
        case (op_reg)
            FPC_OP_ERASE: op_ok = mode_reg != FPC_M_XBLK;
            FPC_OP_CLR_ALL: op_ok = mode_reg == FPC_M_NVG;
            FPC_OP_PWD_UNLOCK: op_ok = mode_reg == FPC_M_PWD && gap_reg == 16'h0000;
            FPC_OP_VG_CLEAR: op_ok = mode_reg == FPC_M_VG;
            default: op_ok = 1'b1;
        endcase
    end

    // Number of bus cycles per operation (the read op is one read)
    function automatic logic [2:0] op_len(input logic [3:0] op);
        case (op)
            FPC_OP_ENT_XBLK, FPC_OP_ENT_LOCKREG, FPC_OP_ENT_PWD: op_len = 3'd3;
            FPC_OP_ENT_NVG, FPC_OP_ENT_FRZ, FPC_OP_ENT_VG: op_len = 3'd3;
            FPC_OP_EXIT_XBLK: op_len = 3'd4;
            FPC_OP_PWD_UNLOCK: op_len = 3'd7;
            FPC_OP_READ: op_len = 3'd1;
            default: op_len = 3'd2;
        endcase
    endfunction

    // Address and data of the current step
    always_comb begin
        cyc_addr = addr_reg;
        cyc_data = 16'h0000;
        cyc_wr = op_reg != FPC_OP_READ;
        case (op_reg)
            FPC_OP_EXIT_SET: cyc_data = {8'h00, step_reg == 3'd0 ? FD_EXIT1 : FD_EXIT2};
            FPC_OP_PROGRAM, FPC_OP_VG_CLEAR: begin
                if (step_reg != 3'd0) begin
                    cyc_data = data_reg;
                    if (op_reg == FPC_OP_VG_CLEAR) cyc_data = {8'h00, FD_GUARD_CLR};
                    else if (mode_reg == FPC_M_NVG || mode_reg == FPC_M_FRZ ||
                             mode_reg == FPC_M_VG) cyc_data = {8'h00, FD_GUARD_SET};
                end else cyc_data = {8'h00, FD_PROG};
            end
            FPC_OP_CLR_ALL, FPC_OP_ERASE: begin
                cyc_data = {8'h00, step_reg == 3'd0 ? FD_ERASE : FD_CLR_ALL};
                if (op_reg == FPC_OP_CLR_ALL) cyc_addr = '0;
            end
            FPC_OP_PWD_UNLOCK: begin
                cyc_addr = '0;
                if (step_reg == 3'd0) cyc_data = {8'h00, FD_PWU_1};
                else if (step_reg == 3'd1) cyc_data = {8'h00, FD_PWU_2};
                else if (step_reg == 3'd6) cyc_data = {8'h00, FD_PWU_END};
                else begin
                    cyc_addr = ADDR_W'(step_reg - 3'd2);
                    cyc_data = pwd_reg[2'(step_reg - 3'd2)];
                end
            end
            FPC_OP_READ: cyc_data = 16'h0000;
            default: begin
                // Unlock preamble then entry or exit code
                cyc_addr = ADDR_W'(step_reg == 3'd1 ? FA_UNL2 : FA_UNL1);
                case (step_reg)
                    3'd0: cyc_data = {8'h00, FD_UNL1};
                    3'd1: cyc_data = {8'h00, FD_UNL2};
                    3'd3: cyc_data = {8'h00, FD_EXIT2};
                    default: begin
                        case (op_reg)
                            FPC_OP_ENT_XBLK: cyc_data = {8'h00, FD_ENT_XBLK};
                            FPC_OP_ENT_LOCKREG: cyc_data = {8'h00, FD_ENT_LOCKREG};
                            FPC_OP_ENT_PWD: cyc_data = {8'h00, FD_ENT_PWD};
                            FPC_OP_ENT_NVG: cyc_data = {8'h00, FD_ENT_NVG};
                            FPC_OP_ENT_FRZ: cyc_data = {8'h00, FD_ENT_FRZ};
                            FPC_OP_ENT_VG: cyc_data = {8'h00, FD_ENT_VG};
                            default: cyc_data = {8'h00, FD_EXIT1};
                        endcase
                    end
                endcase
                // Final 00 of the four-write exit goes to address 0; entry address carries no bank bits
                if (step_reg == 3'd3) cyc_addr = '0;
            end
        endcase
    end

    assign cyc_start = state_reg == FPC_S_RUN;
    assign last_step = step_reg == len_reg - 3'd1;

    // Mode after a completed operation
    always_comb begin
        mode_next = mode_reg;
        case (op_reg)
            FPC_OP_ENT_XBLK: mode_next = FPC_M_XBLK;
            FPC_OP_EXIT_XBLK, FPC_OP_EXIT_SET: mode_next = FPC_M_READ;
            FPC_OP_ENT_LOCKREG: mode_next = FPC_M_LOCKREG;
            FPC_OP_ENT_PWD: mode_next = FPC_M_PWD;
            FPC_OP_ENT_NVG: mode_next = FPC_M_NVG;
            FPC_OP_ENT_FRZ: mode_next = FPC_M_FRZ;
            FPC_OP_ENT_VG: mode_next = FPC_M_VG;
            default: mode_next = mode_reg;
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= FPC_S_IDLE;
            mode_reg <= FPC_M_READ;
            step_reg <= 3'd0;
            len_reg <= 3'd1;
            refused_reg <= 1'b0;
            rd_reg <= 16'h0000;
        end else begin
            case (state_reg)
                FPC_S_IDLE: begin
                    if (cmd_go) begin
                        state_reg <= FPC_S_WAIT;
                        step_reg <= 3'd0;
                        len_reg <= op_len(reg_wdata[3:0]);
                    end
                end
                FPC_S_WAIT: begin
                    // Check legality once op is latched
                    if (op_ok) state_reg <= FPC_S_RUN;
                    else begin
                        refused_reg <= 1'b1;
                        state_reg <= FPC_S_IDLE;
                    end
                end
                FPC_S_RUN: begin
                    if (cyc_done) begin
                        if (op_reg == FPC_OP_READ) rd_reg <= cyc_rdata;
                        if (last_step) begin
                            state_reg <= FPC_S_IDLE;
                            mode_reg <= mode_next;
                        end else step_reg <= step_reg + 3'd1;
                    end
                end
                default: state_reg <= FPC_S_IDLE;
            endcase
            if (cmd_go) refused_reg <= 1'b0;
        end
    end

    // Command accepted only while idle
    assign cmd_go = state_reg == FPC_S_IDLE && reg_wr && reg_addr == RA_CMD;

    // Operation, address and data latches
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_reg <= 4'h0;
            addr_reg <= '0;
            data_reg <= 16'h0000;
            for (int i = 0; i < 4; i++) pwd_reg[i] <= 16'hFFFF;
        end else if (reg_wr) begin
            if (cmd_go) op_reg <= reg_wdata[3:0];
            if (reg_addr == RA_ADDR) addr_reg <= reg_wdata[ADDR_W-1:0];
            if (reg_addr == RA_DATA) data_reg <= reg_wdata[15:0];
            if (reg_addr[3:2] == RA_PWD0[3:2]) pwd_reg[reg_addr[1:0]] <= reg_wdata[15:0];
        end
    end

    // Spacing counter between unlock commands
    always_ff @(posedge ref_clk) begin
        if (!rst_n) gap_reg <= 16'h0000;
        else if (state_reg == FPC_S_RUN && op_reg == FPC_OP_PWD_UNLOCK && cyc_done && last_step)
            gap_reg <= 16'(GAP_CYC);
        else if (gap_reg != 16'h0000) gap_reg <= gap_reg - 16'h0001;
    end

    // Register read port, data one cycle later
    always_ff @(posedge ref_clk) begin
        if (!rst_n) reg_rdata <= 32'h0000_0000;
        else if (reg_rd) begin
            case (reg_addr)
                RA_STATUS: reg_rdata <= {24'h00_0000, 1'b0, refused_reg, gap_reg != 16'h0000,
                                         mode_reg, state_reg != FPC_S_IDLE, 1'b0};
                RA_RDATA: reg_rdata <= {16'h0000, rd_reg};
                RA_ADDR: reg_rdata <= 32'(addr_reg);
                RA_DATA: reg_rdata <= {16'h0000, data_reg};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== bench/fpc_ctrl_assertions.sv
// Pin protocol checker for the flash protection controller.
// Assumes binding into fpc_ctrl; sees only its ports.
`timescale 1ns/1ps
module fpc_ctrl_assertions
    import fpc_pkg::*;
#(
    parameter int ADDR_W = 23
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [ADDR_W-1:0] fl_addr,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_dq_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_low_two;
        !fl_we_n ##1 !fl_we_n ##1 fl_we_n;
    endsequence
    sequence s_cmd_go;
        reg_wr && reg_addr == RA_CMD && reg_wdata[3:0] == FPC_OP_ENT_XBLK;
    endsequence
    property p_rst_idle;
        @(posedge ref_clk) disable iff (1'b0) !rst_n |=> fl_we_n && fl_oe_n && !fl_dq_oe;
    endproperty
    property p_no_overlap;
        !(!fl_we_n && !fl_oe_n);
    endproperty
    property p_we_in_ce;
        !fl_we_n |-> !fl_ce_n;
    endproperty
    property p_no_contend;
        fl_dq_oe |-> fl_oe_n;
    endproperty
    property p_we_len;
        $fell(fl_we_n) |-> s_low_two;
    endproperty
    property p_hold;
        !fl_we_n && $past(!fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_out);
    endproperty
    property p_drive_on_wr;
        !fl_we_n |-> fl_dq_oe;
    endproperty
    property p_cmd_go;
        s_cmd_go |-> ##[1:20] !fl_we_n;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pins busy after reset");
    a_no_overlap: assert property (p_no_overlap) else $error("read and write overlap");
    a_we_in_ce: assert property (p_we_in_ce) else $error("write without chip select");
    a_no_contend: assert property (p_no_contend) else $error("data bus contention");
    a_we_len: assert property (p_we_len) else $error("write pulse length wrong");
    a_hold: assert property (p_hold) else $error("address or data moved in write");
    a_drive_on_wr: assert property (p_drive_on_wr) else $error("write with bus released");
    a_cmd_go: assert property (p_cmd_go) else $error("entry command never started");
endmodule

bind fpc_ctrl fpc_ctrl_assertions #(.ADDR_W(ADDR_W)) u_fpc_ctrl_assertions (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));

// ===== bench/fpc_flash_model.sv
// Behavioural flash holding the protection command sets.
// Assumes one controller on its pins; reads answer at once.
`timescale 1ns/1ps
module fpc_flash_model
    import fpc_pkg::*;
#(
    parameter int ADDR_W = 23
) (
    input wire logic [ADDR_W-1:0] fl_addr,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_dq_oe,
    output logic [15:0] fl_dq_in
);
    fpc_mode_t mode = FPC_M_READ;
    logic [15:0] xb [256] = '{default: 16'hFFFF};
    logic [15:0] pw [4] = '{default: 16'hFFFF};
    logic [15:0] uw [4];
    logic [15:0] nv = 16'h0000;
    logic [15:0] vg = 16'hFFFF;
    logic [15:0] lr = 16'hFFFF;
    logic [15:0] rv;
    logic [15:0] last = 16'h0000;
    logic frz = 1'b1;
    logic pg = 1'b0;
    logic ex = 1'b0;
    logic er = 1'b0;
    int nwr = 0;
    int step = 0;
    int ucnt = 0;
    realtime last_unl = -1.0e6;
    wire [3:0] blk = fl_addr[ADDR_W-1 -: 4];
    wire [11:0] a = fl_addr[11:0];
    wire [7:0] d = fl_dq_out[7:0];
    // Command decoder, one step per completed write
    always @(posedge fl_we_n) begin
        if (fl_ce_n === 1'b0) begin
            nwr++;
            if (pg) begin
                pg = 1'b0;
                case (mode)
                    FPC_M_XBLK: if (fl_addr[7]) xb[fl_addr[7:0]] &= fl_dq_out;
                    FPC_M_LOCKREG: lr &= fl_dq_out; // bits never return
                    FPC_M_PWD: pw[a[1:0]] &= fl_dq_out;
                    FPC_M_NVG: nv[blk] |= frz;
                    FPC_M_FRZ: frz = 1'b0;
                    FPC_M_VG: vg[blk] = d[0];
                    default: ;
                endcase
            end else if (ucnt > 0) begin
                if (ucnt > 1 && ucnt < 6) uw[a[1:0]] = fl_dq_out;
                ucnt++;
                if (ucnt == 7) begin
                    if (uw == pw && $realtime - last_unl >= 1000.0) frz = 1'b1;
                    last_unl = $realtime;
                    ucnt = 0;
                end
            end else if (step == 2 && a == 12'h555) begin
                step = 0;
                case (d)
                    8'h88: mode = FPC_M_XBLK;
                    8'h40: mode = FPC_M_LOCKREG;
                    8'h60: mode = FPC_M_PWD;
                    8'hC0: mode = FPC_M_NVG;
                    8'h50: mode = FPC_M_FRZ;
                    8'hE0: mode = FPC_M_VG;
                    8'h90: ex = 1'b1;
                    default: ; // bypass entry never honoured
                endcase
            end else if (a == 12'h555 && d == 8'hAA) step = 1;
            else if (step == 1 && a == 12'h2AA && d == 8'h55) step = 2;
            else if (ex && d == 8'h00) begin
                mode = FPC_M_READ;
                ex = 1'b0;
            end else if (d == 8'h90) ex = 1'b1;
            else if (d == 8'hA0) pg = 1'b1;
            else if (d == 8'h80) er = (mode != FPC_M_XBLK);
            else if (er && d == 8'h30 && mode == FPC_M_NVG && frz) nv = 16'h0000;
            else if (d == 8'h25 && mode == FPC_M_PWD) ucnt = 1;
        end
    end
    // Read data by mode
    always_comb begin
        case (mode)
            FPC_M_XBLK: rv = xb[fl_addr[7:0]]; // every address reads xb, whole array hidden
            FPC_M_LOCKREG: rv = lr;
            FPC_M_PWD: rv = lr[2] ? pw[a[1:0]] : 16'hFFFF;
            FPC_M_NVG: rv = {15'h0000, !nv[blk]};
            FPC_M_FRZ: rv = {15'h0000, frz};
            FPC_M_VG: rv = {15'h0000, !nv[blk] && vg[blk]};
            default: rv = 16'hA5A5 ^ fl_addr[15:0];
        endcase
    end
    // Released bus shows the inverse of the last word
    always @(posedge fl_oe_n) last = rv;
    assign fl_dq_in = (!fl_oe_n && !fl_ce_n && !fl_dq_oe) ? rv : ~last;
endmodule

// ===== bench/fpc_ctrl_tb.sv
// Self-checking bench for fpc_ctrl against the flash model.
// Assumes the software port as the only stimulus path.
`timescale 1ns/1ps
module fpc_ctrl_tb
    import fpc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata, st, rv;
    logic [22:0] fl_addr;
    logic fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
    logic [15:0] fl_dq_out, fl_dq_in;
    int err_total = 0;
    int n_compared = 0;
    int w0 = 0;
    localparam logic [31:0] B3 = 32'h0018_0000;
    localparam logic [31:0] B5 = 32'h0028_0000;
    fpc_ctrl u_fpc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in));
    fpc_flash_model u_fpc_flash_model (.fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in));
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge ref_clk);
    endtask
    task automatic op(input logic [3:0] c);
        wr(RA_CMD, {28'h000_0000, c});
        rd(RA_STATUS, st);
        for (int i = 0; i < 300 && st[1] !== 1'b0; i++) begin
            rd(RA_STATUS, st);
        end
        chk({31'h0000_0000, st[1]}, 32'h0000_0000);
    endtask
    task automatic cw(input logic [31:0] n);
        chk(u_fpc_flash_model.nwr - w0, n);
        w0 = u_fpc_flash_model.nwr;
    endtask
    task automatic rdf(input logic [31:0] ad, input logic [15:0] exp);
        wr(RA_ADDR, ad);
        op(FPC_OP_READ);
        rd(RA_RDATA, rv);
        chk({16'h0000, rv[15:0]}, {16'h0000, exp});
    endtask
    task automatic prog(input logic [31:0] ad, input logic [31:0] dt);
        wr(RA_ADDR, ad);
        wr(RA_DATA, dt);
        op(FPC_OP_PROGRAM);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(RA_STATUS, st);
        chk({26'h000_0000, st[6:1]}, 32'h0000_0000);
        chk({29'h0000_0000, fl_ce_n, fl_we_n, fl_oe_n}, 32'h0000_0007);
        rd(4'h7, rv);
        chk(rv, 32'h0000_0000);
    endtask
    task automatic t_xblk();
        w0 = u_fpc_flash_model.nwr;
        op(FPC_OP_ENT_XBLK);
        chk({29'h0000_0000, st[4:2]}, 32'h0000_0001);
        cw(32'h0000_0003);
        rdf(32'h0000_0000, 16'hFFFF);
        op(FPC_OP_ERASE);
        chk({31'h0000_0000, st[6]}, 32'h0000_0001);
        cw(32'h0000_0000);
        op(FPC_OP_EXIT_XBLK);
        chk({29'h0000_0000, st[4:2]}, 32'h0000_0000);
        cw(32'h0000_0004);
        rdf(32'h0000_0000, 16'hA5A5);
    endtask
    task automatic t_guard();
        op(FPC_OP_ENT_NVG);
        prog(B3, 32'h0000_0000);
        rdf(B3, 16'h0000);
        op(FPC_OP_EXIT_SET);
        chk({29'h0000_0000, u_fpc_flash_model.mode}, 32'h0000_0000);
        op(FPC_OP_ENT_VG);
        prog(B5, 32'h0000_0000);
        rdf(B5, 16'h0000);
        op(FPC_OP_VG_CLEAR);
        rdf(B5, 16'h0001);
        rdf(B3, 16'h0000);
        op(FPC_OP_EXIT_SET);
    endtask
    task automatic t_freeze();
        op(FPC_OP_ENT_FRZ);
        prog(32'h0000_0000, 32'h0000_0000);
        chk({31'h0000_0000, u_fpc_flash_model.frz}, 32'h0000_0000);
        op(FPC_OP_EXIT_SET);
        op(FPC_OP_ENT_NVG);
        op(FPC_OP_CLR_ALL);
        rdf(B3, 16'h0000);
        prog(B5, 32'h0000_0000);
        rdf(B5, 16'h0001);
        op(FPC_OP_EXIT_SET);
    endtask
    task automatic t_pwd();
        op(FPC_OP_ENT_PWD);
        prog(32'h0000_0000, 32'h0000_1234);
        rdf(32'h0000_0001, 16'hFFFF);
        rdf(32'h0000_0000, 16'h1234);
        wr(RA_PWD0, 32'h0000_1234);
        for (int i = 1; i < 4; i++) begin
            wr(RA_PWD0 + 4'(i), 32'h0000_FFFF);
        end
        op(FPC_OP_PWD_UNLOCK);
        chk({31'h0000_0000, st[6]}, 32'h0000_0000);
        chk({31'h0000_0000, u_fpc_flash_model.frz}, 32'h0000_0001);
        op(FPC_OP_PWD_UNLOCK);
        chk({31'h0000_0000, st[6]}, 32'h0000_0001);
        op(FPC_OP_EXIT_SET);
        op(FPC_OP_ENT_NVG);
        op(FPC_OP_CLR_ALL);
        rdf(B3, 16'h0001);
        op(FPC_OP_EXIT_SET);
        op(FPC_OP_ENT_LOCKREG);
        prog(32'h0000_0000, 32'h0000_FFFB);
        rdf(32'h0000_0000, 16'hFFFB);
        op(FPC_OP_EXIT_SET);
        op(FPC_OP_ENT_PWD);
        rdf(32'h0000_0000, 16'hFFFF);
        op(FPC_OP_EXIT_SET);
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // Watchdog
    initial begin
        #(40 * 40000);
        err_total++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_xblk();
        t_guard();
        t_freeze();
        t_pwd();
        end_of_test();
    end
endmodule
